// file: verilog/pmbw_defines.svh
// Purpose: Constants for the 64-bit burst write data-phase block.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef PMBW_DEFINES_SVH
`define PMBW_DEFINES_SVH

`define PMBW_CNT_W          8
`define PMBW_CNT_ZERO       8'h00
`define PMBW_CNT_ONE        8'h01
`define PMBW_REPORT_IDLE    4'h0
`define PMBW_REPORT_XFER    4'h1
`define PMBW_REPORT_BUSTERM 4'h2
`define PMBW_CAUSE_NONE     2'h0
`define PMBW_CAUSE_NORMAL   2'h1
`define PMBW_CAUSE_ABORTED  2'h2

`endif

// file: verilog/pmbw_pkg.sv
// Purpose: Types for the 64-bit burst write data-phase block.
// Assumes: Nothing beyond the defines header.
// Notes:   State of the burst sequencer.
`default_nettype none
package pmbw_pkg;
  typedef enum logic [1:0] {
    PMBW_IDLE,
    PMBW_BURST,
    PMBW_RELEASE
  } pmbw_state_t;
endpackage : pmbw_pkg
`default_nettype wire

// file: verilog/pmbw_write_burst.sv
// Purpose: Data phases and termination of a 64-bit PCI burst write as initiator.
// Assumes: Address phase and arbitration done outside; start pulses in the cycle after the address phase.
// Notes:   All bus outputs come from flip-flops; the testbench resolves only the shared irdyn wire from its enable.
`include "pmbw_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - A data phase completes in any cycle with irdyn and trdyn both low.
// - Keep framen low while more data phases remain; release it for the last.
// - Decrement the remaining beat counter the cycle after a completed data phase.
// - Ready and trdyn low last cycle: assert both transfer strobes now.
// - After the target takes a quadword, drive the next one onto ad and cben.
// - Ready low last cycle keeps irdyn low in the current cycle.
// - Final data phase: framen, req64n and both strobes go high.
// - After the final phase: release framen, req64n, ad, cben; irdyn high; counter zero.
// - After the burst: report bus termination, cause normal when the last phase completed.
module pmbw_write_burst
  import pmbw_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  // Burst start from the address-phase logic
  input  wire logic                   burst_start,
  input  wire logic [`PMBW_CNT_W-1:0] burst_length,
  // Local master side
  input  wire logic                   local_source_ready_n,
  input  wire logic [63:0]            local_data_in,
  input  wire logic [7:0]             local_byte_enable_in,
  output logic                        local_low_word_taken_n,
  output logic                        local_high_word_taken_n,
  output logic [`PMBW_CNT_W-1:0]      remaining_beat_counter,
  output logic [3:0]                  initiator_state_report,
  output logic [1:0]                  end_cause_report,
  // PCI bus side
  input  wire logic                   trdyn,
  output logic                        framen_o,
  output logic                        framen_oe,
  output logic                        req64n_o,
  output logic                        req64n_oe,
  output logic                        irdyn_o,
  output logic                        irdyn_oe,
  output logic [63:0]                 ad_o,
  output logic                        ad_oe,
  output logic [7:0]                  cben_o,
  output logic                        cben_oe
);

  // ==========================================================================
  // State
  // ==========================================================================
  pmbw_state_t              state_q, state_d;
  logic [`PMBW_CNT_W-1:0]   beats_q, beats_d;
  logic [`PMBW_CNT_W-1:0]   fetch_q, fetch_d;
  logic                     strobe_n_q, strobe_n_d;
  logic                     owed_q, owed_d;
  logic                     framen_q, framen_d;
  logic                     irdyn_q, irdyn_d;
  logic                     drive_q, drive_d;
  logic                     irdy_oe_q, irdy_oe_d;
  logic [63:0]              ad_q, ad_d;
  logic [7:0]               cben_q, cben_d;
  logic [63:0]              hold_ad_q, hold_ad_d;
  logic [7:0]               hold_be_q, hold_be_d;
  logic [3:0]               report_q, report_d;
  logic [1:0]               cause_q, cause_d;
  logic                     phase_done;
  logic                     final_phase;

  assign phase_done  = (state_q == PMBW_BURST) && !irdyn_q && !trdyn;
  assign final_phase = (beats_q == `PMBW_CNT_ONE);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    state_d    = state_q;
    beats_d    = beats_q;
    fetch_d    = fetch_q;
    strobe_n_d = 1'b1;
    owed_d     = owed_q;
    framen_d   = framen_q;
    irdyn_d    = irdyn_q;
    drive_d    = drive_q;
    irdy_oe_d  = irdy_oe_q;
    ad_d       = ad_q;
    cben_d     = cben_q;
    hold_ad_d  = hold_ad_q;
    hold_be_d  = hold_be_q;
    report_d   = report_q;
    cause_d    = cause_q;
    // A quadword marked by the strobes is parked until its bus slot opens.
    if (!strobe_n_q)
    begin
      hold_ad_d = local_data_in;
      hold_be_d = local_byte_enable_in;
    end
    case (state_q)
      PMBW_IDLE:
      begin
        irdy_oe_d = 1'b0;
        if (burst_start && (burst_length != `PMBW_CNT_ZERO))
        begin
          state_d    = PMBW_BURST;
          beats_d    = burst_length;
          // The first quadword is taken straight from the local port at this edge.
          // The strobe that follows already marks the second one, so a single-beat
          // burst gets no strobe at all.
          fetch_d    = (burst_length == `PMBW_CNT_ONE) ? `PMBW_CNT_ZERO : burst_length - 8'h02;
          ad_d       = local_data_in;
          cben_d     = local_byte_enable_in;
          strobe_n_d = (burst_length == `PMBW_CNT_ONE);
          owed_d     = 1'b0;
          framen_d   = (burst_length == `PMBW_CNT_ONE);
          irdyn_d    = 1'b0;
          drive_d    = 1'b1;
          irdy_oe_d  = 1'b1;
          report_d   = `PMBW_REPORT_XFER;
          cause_d    = `PMBW_CAUSE_NONE;
        end
      end
      PMBW_BURST:
      begin
        // A quadword offered while the target stalls stays owed a strobe.
        // Without this the last quadword would never be fetched after a stall.
        if (!trdyn && (fetch_q != `PMBW_CNT_ZERO) && (!local_source_ready_n || owed_q))
        begin
          strobe_n_d = 1'b0;
          fetch_d    = fetch_q - `PMBW_CNT_ONE;
          owed_d     = 1'b0;
        end
        else if (trdyn && !local_source_ready_n && (fetch_q != `PMBW_CNT_ZERO))
          owed_d = 1'b1;
        if (!local_source_ready_n)
          irdyn_d = 1'b0;
        if (phase_done)
        begin
          beats_d = beats_q - `PMBW_CNT_ONE;
          if (final_phase)
          begin
            state_d    = PMBW_RELEASE;
            drive_d    = 1'b0;
            irdyn_d    = 1'b1;
            strobe_n_d = 1'b1;
            report_d   = `PMBW_REPORT_BUSTERM;
            cause_d    = `PMBW_CAUSE_NORMAL;
          end
          else
          begin
            ad_d     = !strobe_n_q ? local_data_in : hold_ad_q;
            cben_d   = !strobe_n_q ? local_byte_enable_in : hold_be_q;
            framen_d = (beats_q == 8'h02);
            if (beats_q == 8'h02)
              strobe_n_d = 1'b1;
          end
        end
      end
      PMBW_RELEASE:
      begin
        // irdyn is driven high for one cycle before the pin is let go.
        state_d   = PMBW_IDLE;
        irdy_oe_d = 1'b0;
        framen_d  = 1'b1;
      end
      default:
      begin
        state_d = PMBW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q    <= PMBW_IDLE;
      beats_q    <= `PMBW_CNT_ZERO;
      fetch_q    <= `PMBW_CNT_ZERO;
      strobe_n_q <= 1'b1;
      owed_q     <= 1'b0;
      framen_q   <= 1'b1;
      irdyn_q    <= 1'b1;
      drive_q    <= 1'b0;
      irdy_oe_q  <= 1'b0;
      ad_q       <= 64'h0;
      cben_q     <= 8'h00;
      hold_ad_q  <= 64'h0;
      hold_be_q  <= 8'h00;
      report_q   <= `PMBW_REPORT_IDLE;
      cause_q    <= `PMBW_CAUSE_NONE;
    end
    else
    begin
      state_q    <= state_d;
      beats_q    <= beats_d;
      fetch_q    <= fetch_d;
      strobe_n_q <= strobe_n_d;
      owed_q     <= owed_d;
      framen_q   <= framen_d;
      irdyn_q    <= irdyn_d;
      drive_q    <= drive_d;
      irdy_oe_q  <= irdy_oe_d;
      ad_q       <= ad_d;
      cben_q     <= cben_d;
      hold_ad_q  <= hold_ad_d;
      hold_be_q  <= hold_be_d;
      report_q   <= report_d;
      cause_q    <= cause_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // One flop feeds both strobes so the two halves can never split.
  assign local_low_word_taken_n  = strobe_n_q;
  assign local_high_word_taken_n = strobe_n_q;
  assign remaining_beat_counter  = beats_q;
  assign initiator_state_report  = report_q;
  assign end_cause_report        = cause_q;
  assign framen_o                = framen_q;
  assign framen_oe               = drive_q;
  assign req64n_o                = framen_q;
  assign req64n_oe               = drive_q;
  assign irdyn_o                 = irdyn_q;
  assign irdyn_oe                = irdy_oe_q;
  assign ad_o                    = ad_q;
  assign ad_oe                   = drive_q;
  assign cben_o                  = cben_q;
  assign cben_oe                 = drive_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_frame_held_mid: assert property (
    (state_q == PMBW_BURST && beats_q > 8'h01) |-> !framen_q)
    else $error("framen released before the final data phase");
  a_count_decrement: assert property (
    phase_done |=> beats_q == $past(beats_q) - 8'h01)
    else $error("beat counter did not drop after a completed phase");
  a_strobe_follows_ready: assert property (
    (state_q == PMBW_BURST && !local_source_ready_n && !trdyn && fetch_q != 8'h00
      && !(phase_done && beats_q == 8'h02))
      |=> !local_low_word_taken_n)
    else $error("strobes missing after ready and trdyn");
  a_strobes_paired: assert property (
    local_low_word_taken_n == local_high_word_taken_n)
    else $error("low and high strobes differ");
  a_next_word_driven: assert property (
    (phase_done && beats_q > 8'h01 && !strobe_n_q) |=> ad_o == $past(local_data_in))
    else $error("next quadword not moved to ad");
  a_irdy_kept: assert property (
    (state_q == PMBW_BURST && !local_source_ready_n && !phase_done) |=> !irdyn_o)
    else $error("irdyn released while ready was low");
  a_final_frame_up: assert property (
    (state_q == PMBW_BURST && final_phase) |-> framen_o && req64n_o && local_low_word_taken_n)
    else $error("final phase without framen, req64n and strobes high");
  a_release_bus: assert property (
    (phase_done && final_phase) |=> !framen_oe && !ad_oe && !cben_oe && irdyn_o
      && beats_q == 8'h00 ##1 !irdyn_oe)
    else $error("bus not released after the final phase");
  a_end_report: assert property (
    (phase_done && final_phase) |=> initiator_state_report == 4'h2 && end_cause_report == 2'h1)
    else $error("termination not reported after the burst");

  c_burst_start: cover property (state_q == PMBW_IDLE && burst_start ##1 state_q == PMBW_BURST);
  c_target_wait: cover property (state_q == PMBW_BURST && trdyn ##1 phase_done);
  c_long_burst:  cover property (phase_done && !final_phase ##[1:20] phase_done && final_phase);

endmodule : pmbw_write_burst
`default_nettype wire

// file: tb/pmbw_target_model.sv
// Purpose: Behavioural bus target that answers the burst write block.
// Assumes: Control wires have pull-ups, so a released wire reads high.
// Notes:   The stall input lets the bench hold off data phase completion.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bus target model
module pmbw_target_model
(
  // Shared bus wire seen by the target
  input  wire logic irdyn,
  // Bench control
  input  wire logic stall,
  // Target response
  output logic      trdyn,
  output logic      devseln,
  output logic      ack64n
);
  logic active;

  // Answers in the same cycle so back-to-back phases are exercised; once the
  // initiator's irdyn reads high the target drives its lines high itself.
  assign active  = (irdyn === 1'b0);
  assign trdyn   = (active && stall === 1'b0) ? 1'b0 : 1'b1;
  assign devseln = active ? 1'b0 : 1'b1;
  assign ack64n  = active ? 1'b0 : 1'b1;
endmodule : pmbw_target_model
`default_nettype wire

// file: tb/pmbw_write_burst_bench.sv
// Purpose: Self-checking bench for the burst write data-phase block.
// Assumes: The bench plays the local master; the target model plays the bus target.
// Notes:   Inputs change at the falling edge; outputs are judged just after it.
`include "pmbw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pmbw_write_burst_bench;
  logic                   clock = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   burst_start = 1'b0;
  logic [`PMBW_CNT_W-1:0] burst_length = `PMBW_CNT_ZERO;
  logic                   local_source_ready_n = 1'b1;
  logic [63:0]            local_data_in = 64'h0;
  logic [7:0]             local_byte_enable_in = 8'h00;
  logic                   stall = 1'b0;
  logic                   local_low_word_taken_n, local_high_word_taken_n;
  logic [`PMBW_CNT_W-1:0] remaining_beat_counter;
  logic [3:0]             initiator_state_report;
  logic [1:0]             end_cause_report;
  logic                   trdyn, devseln, ack64n, irdyn_w;
  logic                   framen_o, framen_oe, req64n_o, req64n_oe, irdyn_o, irdyn_oe, ad_oe, cben_oe;
  logic [63:0]            ad_o;
  logic [7:0]             cben_o;
  int                     num_errors = 0;
  int                     n_compared = 0;

  always #25 clock = ~clock;
  assign irdyn_w = irdyn_oe ? irdyn_o : 1'b1;

  pmbw_write_burst pmbw_write_burst_i (.clock, .reset_n, .burst_start, .burst_length, .local_source_ready_n,
    .local_data_in, .local_byte_enable_in, .local_low_word_taken_n, .local_high_word_taken_n,
    .remaining_beat_counter, .initiator_state_report, .end_cause_report, .trdyn, .framen_o, .framen_oe,
    .req64n_o, .req64n_oe, .irdyn_o, .irdyn_oe, .ad_o, .ad_oe, .cben_o, .cben_oe);
  pmbw_target_model pmbw_target_model_i (.irdyn(irdyn_w), .stall, .trdyn, .devseln, .ack64n);

  // ============================================================
  // Shared tasks
  function automatic logic [63:0] word(input int k);
    return {16'hA5C3, k[15:0], 16'h3C5A, ~k[15:0]};
  endfunction : word

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Local master: shows quadword idx and holds ready low while more remain.
  task automatic drive(input int idx, input int len);
    local_data_in = word(idx);
    local_byte_enable_in = 8'hF0 ^ idx[7:0];
    local_source_ready_n = (idx >= len - 1);
  endtask : drive

  // Runs one burst of len phases; the target stalls for sc cycles from cycle sf.
  task automatic run_burst(input int len, input int sf, input int sc);
    int   k;
    int   n;
    int   idx;
    logic took;
    logic pend;
    k = 0;
    n = 0;
    idx = 0;
    // The start edge itself takes quadword 0, so the master moves on at once.
    took = 1'b1;
    pend = 1'b0;
    @(negedge clock);
    burst_length = len[`PMBW_CNT_W-1:0];
    burst_start = 1'b1;
    drive(0, len);
    while (k < len && n < len + sc + 8)
    begin
      @(negedge clock);
      burst_start = 1'b0;
      n++;
      if (took)
        idx++;
      drive(idx, len);
      stall = (n >= sf && n < sf + sc);
      #1;
      took = (local_low_word_taken_n === 1'b0);
      check(local_high_word_taken_n, local_low_word_taken_n);
      if (pend && framen_o === 1'b0)
        check(local_low_word_taken_n, 1'b0);
      pend = (local_source_ready_n === 1'b0 && trdyn === 1'b0);
      if (ad_oe === 1'b1)
        check(remaining_beat_counter, len - k);
      if (ad_oe === 1'b1)
        check({initiator_state_report, end_cause_report}, {`PMBW_REPORT_XFER, `PMBW_CAUSE_NONE});
      if (stall)
        check({irdyn_oe, irdyn_o}, 2'b10);
      if (irdyn_o === 1'b0 && trdyn === 1'b0)
      begin
        check(ad_o, word(k));
        check(cben_o, 8'hF0 ^ k[7:0]);
        check({framen_o, req64n_o}, {2{k == len - 1}});
        if (k == len - 1)
          check(local_low_word_taken_n, 1'b1);
        k++;
      end
    end
    if (k < len)
    begin
      num_errors++;
      end_sim();
    end
    @(negedge clock);
    check({framen_oe, req64n_oe, ad_oe, cben_oe, irdyn_o}, 5'b00001);
    check(remaining_beat_counter, `PMBW_CNT_ZERO);
    check({initiator_state_report, end_cause_report}, {`PMBW_REPORT_BUSTERM, `PMBW_CAUSE_NORMAL});
    check({trdyn, devseln, ack64n}, 3'b111);
  endtask : run_burst

  // ============================================================
  // Scenarios
  task automatic t_reset();
    check({framen_oe, req64n_oe, irdyn_oe, ad_oe, cben_oe}, 5'h00);
    check({local_low_word_taken_n, local_high_word_taken_n, framen_o, req64n_o, irdyn_o}, 5'h1F);
    check({remaining_beat_counter, initiator_state_report, end_cause_report}, 14'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bursts();
    run_burst(3, 99, 0);
    run_burst(1, 99, 0);
    run_burst(5, 3, 3);
    run_burst(255, 100, 2);
    $display("test bursts done");
  endtask : t_bursts

  task automatic t_refuse();
    @(negedge clock);
    burst_length = `PMBW_CNT_ZERO;
    burst_start = 1'b1;
    @(negedge clock);
    burst_start = 1'b0;
    @(negedge clock);
    check({framen_oe, ad_oe, initiator_state_report}, {2'b00, `PMBW_REPORT_BUSTERM});
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_midreset();
    @(negedge clock);
    burst_length = 8'h04;
    burst_start = 1'b1;
    @(negedge clock);
    burst_start = 1'b0;
    @(negedge clock);
    reset_n = 1'b0;
    #1;
    check({framen_oe, req64n_oe, irdyn_oe, ad_oe, cben_oe, initiator_state_report}, 9'h000);
    @(negedge clock);
    reset_n = 1'b1;
    run_burst(2, 99, 0);
    $display("test midreset done");
  endtask : t_midreset

  initial
  begin
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_bursts();
    t_refuse();
    t_midreset();
    end_sim();
  end
endmodule : pmbw_write_burst_bench
`default_nettype wire
